// file: core/uoe_map.vh
// Register offsets, field positions, reset values and bus beat size for the OUT endpoint control block
`ifndef UOE_MAP_VH
`define UOE_MAP_VH
// Register byte offsets
`define UOE_OFF_EP0_TSIZE 18'h3CB10
`define UOE_OFF_EP0_DMA 18'h3CB14
`define UOE_OFF_EPX_CTL 18'h3CB20
`define UOE_OFF_EVENTS 18'h3CB28
`define UOE_OFF_EP0_EVENTS 18'h3CB08
// Control register fields
`define UOE_CTL_ENABLE 31
`define UOE_CTL_DISABLE 30
`define UOE_CTL_SET_PID1 29
`define UOE_CTL_SET_PID0 28
`define UOE_CTL_SET_NAK 27
`define UOE_CTL_CLR_NAK 26
`define UOE_CTL_STALL 21
`define UOE_CTL_SNOOP 20
`define UOE_CTL_TYPE_HI 19
`define UOE_CTL_TYPE_LO 18
`define UOE_CTL_NAK 17
`define UOE_CTL_PID 16
// Transfer size fields
`define UOE_TS_SETUP_HI 30
`define UOE_TS_SETUP_LO 29
`define UOE_TS_PKT 19
`define UOE_TS_BYTES_HI 6
`define UOE_TS_BYTES_LO 0
// Event register fields
`define UOE_EV_DONE 0
`define UOE_EV_DISABLED 1
`define UOE_EV_SETUP 3
`define UOE_EV_B2B_SETUP 6
// Endpoint type codes
`define UOE_TYPE_CONTROL 2'h0
`define UOE_TYPE_ISO 2'h1
// Handshake codes
`define UOE_HS_ACK 2'h0
`define UOE_HS_NAK 2'h1
`define UOE_HS_STALL 2'h2
`define UOE_HS_NONE 2'h3
// Reset values and back-to-back SETUP limit
`define UOE_RST_TSIZE 32'h0000_0000
`define UOE_RST_DMA 32'h0000_0000
`define UOE_MAX_SETUP 2'h3
// Bytes moved per system bus transaction
`define UOE_BUS_BEAT 32'h0000_0004
`endif

// file: core/uoe_setup_store.v
// Small memory holding the three most recent SETUP packets of endpoint 0
`timescale 1ns/100ps
module uoe_setup_store #(
	parameter WIDTH = 64,
	parameter DEPTH = 3,
	parameter AW = 2
) (
	// Clock
	input wire aclk,
	input wire aclken,
	// Write side
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [WIDTH-1:0] wr_data,
	// Read side
	input wire [AW-1:0] rd_addr,
	output reg [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	always @(posedge aclk) begin
		if (aclken) begin
			if (wr_en)
				mem[wr_addr] <= wr_data;
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// file: core/uoe_out_ep_ctrl.v
// OUT endpoint control, transfer size, DMA address and event flag logic
// Notes on behaviour
// RULE1: Disabled flag rises after software disable completes
// RULE2: Done flag needs bus and USB sides finished
// RULE3: Software programs size before enable, reads after
// RULE4: Device owns and updates size while enabled
// RULE5: Two-bit field counts allowed consecutive SETUP packets
// RULE6: Signal endpoint 0 only after byte count consumed
// RULE7: Software may set count to max packet size
// RULE8: Byte count drops per packet moved to memory
// RULE9: DMA address holds start, advances per bus beat
// RULE10: Over three back-to-back SETUPs overwrite stored one
// RULE11: Software writes aligned DMA address only
// RULE12: Enable clears before setup, disabled, done flags
// RULE13: Software enables control endpoint before SETUP storage
// RULE14: Disable only while enabled; cleared before flag
// RULE15: PID-set writes load the PID parity field
// RULE16: Software sets first PID after activation
// RULE17: Set and clear NAK; device sets after SETUP
// RULE18: NAK state refuses OUT data despite room
// RULE19: STALL beats NAK; only software clears (code ignores STALL on ISO type; on control type only a SETUP token clears it)
// RULE20: Control endpoint SETUP token clears STALL
// RULE21: SETUP data always answered with ACK
// RULE22: Snoop mode stores packets without checking them
`timescale 1ns/100ps
`include "uoe_map.vh"
module uoe_out_ep_ctrl #(
	parameter SETUP_WIDTH = 64
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	input wire aclken,
	// AXI4-Lite write address
	input wire [17:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [17:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// USB packet engine, endpoint 0 (same clock)
	input wire ep0_setup_rx,
	input wire [SETUP_WIDTH-1:0] ep0_setup_data,
	input wire ep0_beat,
	input wire ep0_pkt_stored,
	input wire [6:0] ep0_pkt_bytes,
	input wire ep0_usb_done,
	// USB packet engine, endpoint x (same clock)
	input wire epx_setup_token,
	input wire epx_out_data,
	input wire epx_disable_ack,
	input wire epx_xfer_done,
	output reg [1:0] epx_handshake,
	output reg epx_snoop,
	output reg epx_pid,
	// SETUP store readback
	input wire [1:0] ep0_setup_rd_idx,
	output wire [SETUP_WIDTH-1:0] ep0_setup_rd_data
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	reg [1:0] setup_cnt_reg, b2b_run_reg, setup_wr_reg, type_reg;
	reg [6:0] bytes_reg;
	reg [31:0] dma_reg;
	reg pkt_cnt_reg, ep0_enable_reg, ep0_done_reg, ep0_setup_ev_reg;
	reg ep0_b2b_reg, enable_reg, disable_reg, nak_reg, stall_reg;
	reg snoop_reg, pid_reg, done_ev_reg, dis_ev_reg, setup_ev_reg;

	// ----------------------------------------------------------------
	// AXI4-Lite handshake
	// ----------------------------------------------------------------
	reg [17:0] awaddr_reg;
	reg aw_held_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg w_held_reg;
	wire wr_fire, rd_fire;
	wire [31:0] wd;

	// Address and data are taken in either order, then one write fires
	// Readies drop with the enable so no beat is lost while frozen
	assign s_axi_awready = aclken && !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = aclken && !w_held_reg && !s_axi_bvalid;
	assign wr_fire = aclken && aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = aclken && !s_axi_rvalid;
	assign rd_fire = aclken && s_axi_arvalid && s_axi_arready;
	assign wd = wdata_reg & {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

	function is_reg;
		input [17:0] a;
		input [17:0] off;
		begin
			is_reg = (a[17:2] == off[17:2]);
		end
	endfunction

	wire w_ctl = wr_fire && is_reg(awaddr_reg, `UOE_OFF_EPX_CTL);
	wire w_ts = wr_fire && is_reg(awaddr_reg, `UOE_OFF_EP0_TSIZE);
	wire w_dma = wr_fire && is_reg(awaddr_reg, `UOE_OFF_EP0_DMA);
	wire w_ev = wr_fire && is_reg(awaddr_reg, `UOE_OFF_EVENTS);
	wire w_ev0 = wr_fire && is_reg(awaddr_reg, `UOE_OFF_EP0_EVENTS);
	wire w_map = w_ctl || w_ts || w_dma || w_ev || w_ev0;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 18'h00000;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (aclken) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_map ? 2'h0 : 2'h3;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Endpoint 0 transfer size, DMA address and events
	// ----------------------------------------------------------------
	wire [6:0] bytes_left = (ep0_pkt_bytes >= bytes_reg) ? 7'h00 :
		bytes_reg - ep0_pkt_bytes;
	// Both sides must be finished before the transfer counts as done
	wire ep0_finish = ep0_enable_reg && ep0_usb_done &&
		(bytes_reg == 7'h00) && !ep0_pkt_stored; // [RULE2] [RULE6]
	wire [1:0] next_wr = (setup_wr_reg == 2'h2) ? 2'h0 : setup_wr_reg + 2'h1;

	always @(posedge aclk) begin
		if (!aresetn) begin
			setup_cnt_reg <= 2'h0;
			pkt_cnt_reg <= 1'b0;
			bytes_reg <= 7'h00;
			dma_reg <= `UOE_RST_DMA;
			ep0_enable_reg <= 1'b0;
			ep0_done_reg <= 1'b0;
			ep0_setup_ev_reg <= 1'b0;
			ep0_b2b_reg <= 1'b0;
			b2b_run_reg <= 2'h0;
			setup_wr_reg <= 2'h0;
		end else if (aclken) begin
			// Software owns the size only while the endpoint is idle
			if (w_ts && !ep0_enable_reg) begin // [RULE3]
				setup_cnt_reg <= wd[`UOE_TS_SETUP_HI:`UOE_TS_SETUP_LO]; // [RULE5]
				pkt_cnt_reg <= wd[`UOE_TS_PKT];
				bytes_reg <= wd[`UOE_TS_BYTES_HI:`UOE_TS_BYTES_LO];
				ep0_enable_reg <= 1'b1;
			end
			if (w_dma)
				dma_reg <= {wd[31:2], 2'b00};
			else if (ep0_beat && ep0_enable_reg)
				dma_reg <= dma_reg + `UOE_BUS_BEAT; // [RULE9]
			if (ep0_pkt_stored && ep0_enable_reg) begin // [RULE4]
				bytes_reg <= bytes_left; // [RULE8]
				pkt_cnt_reg <= 1'b0;
			end
			if (ep0_setup_rx && ep0_enable_reg) begin
				if (setup_cnt_reg != 2'h0)
					setup_cnt_reg <= setup_cnt_reg - 2'h1; // [RULE5]
				// Past three in a row the oldest slot is reused
				setup_wr_reg <= next_wr; // [RULE10]
				if (b2b_run_reg == `UOE_MAX_SETUP)
					ep0_b2b_reg <= 1'b1;
				else
					b2b_run_reg <= b2b_run_reg + 2'h1;
				ep0_setup_ev_reg <= 1'b1;
				ep0_enable_reg <= 1'b0; // [RULE12]
			end else if (ep0_pkt_stored) begin
				b2b_run_reg <= 2'h0;
			end
			if (ep0_finish) begin
				ep0_enable_reg <= 1'b0; // [RULE12]
				ep0_done_reg <= 1'b1;
			end
			// Set wins over a clear in the same cycle
			if (w_ev0) begin
				if (wd[`UOE_EV_DONE] && !ep0_finish)
					ep0_done_reg <= 1'b0;
				if (wd[`UOE_EV_SETUP] && !ep0_setup_rx)
					ep0_setup_ev_reg <= 1'b0;
				if (wd[`UOE_EV_B2B_SETUP] && !ep0_setup_rx)
					ep0_b2b_reg <= 1'b0;
			end
		end
	end

	uoe_setup_store #(
		.WIDTH(SETUP_WIDTH),
		.DEPTH(3),
		.AW(2)
	) u_store (
		.aclk(aclk),
		.aclken(aclken),
		.wr_en(ep0_setup_rx && ep0_enable_reg), // [RULE10]
		.wr_addr(setup_wr_reg),
		.wr_data(ep0_setup_data),
		.rd_addr(ep0_setup_rd_idx),
		.rd_data(ep0_setup_rd_data)
	);

	// ----------------------------------------------------------------
	// Endpoint x control register
	// ----------------------------------------------------------------
	wire is_ctrl = (type_reg == `UOE_TYPE_CONTROL);
	wire dis_finish = disable_reg && epx_disable_ack;
	wire xfer_finish = enable_reg && epx_xfer_done;
	wire setup_hit = epx_setup_token && is_ctrl;

	always @(posedge aclk) begin
		if (!aresetn) begin
			enable_reg <= 1'b0;
			disable_reg <= 1'b0;
			nak_reg <= 1'b0;
			stall_reg <= 1'b0;
			snoop_reg <= 1'b0;
			type_reg <= `UOE_TYPE_CONTROL;
			pid_reg <= 1'b0;
			done_ev_reg <= 1'b0;
			dis_ev_reg <= 1'b0;
			setup_ev_reg <= 1'b0;
		end else if (aclken) begin
			if (w_ctl) begin
				if (wd[`UOE_CTL_ENABLE])
					enable_reg <= 1'b1;
				if (wd[`UOE_CTL_DISABLE] && enable_reg) // [RULE14]
					disable_reg <= 1'b1;
				if (wd[`UOE_CTL_SET_PID1])
					pid_reg <= 1'b1; // [RULE15]
				else if (wd[`UOE_CTL_SET_PID0])
					pid_reg <= 1'b0; // [RULE15]
				if (wd[`UOE_CTL_SET_NAK])
					nak_reg <= 1'b1; // [RULE17]
				else if (wd[`UOE_CTL_CLR_NAK])
					nak_reg <= 1'b0; // [RULE17]
				if (wd[`UOE_CTL_STALL])
					stall_reg <= 1'b1;
				else if (!is_ctrl)
					stall_reg <= 1'b0; // [RULE19]
				snoop_reg <= wd[`UOE_CTL_SNOOP];
				type_reg <= wd[`UOE_CTL_TYPE_HI:`UOE_CTL_TYPE_LO];
			end
			if (setup_hit) begin
				stall_reg <= 1'b0; // [RULE20]
				nak_reg <= 1'b1; // [RULE17]
				enable_reg <= 1'b0; // [RULE12]
				setup_ev_reg <= 1'b1;
			end
			if (dis_finish) begin
				enable_reg <= 1'b0; // [RULE12]
				disable_reg <= 1'b0; // [RULE14]
				dis_ev_reg <= 1'b1; // [RULE1]
			end else if (xfer_finish) begin
				enable_reg <= 1'b0; // [RULE12]
				done_ev_reg <= 1'b1; // [RULE2]
			end
			if (w_ev) begin
				if (wd[`UOE_EV_DONE] && !(xfer_finish && !dis_finish))
					done_ev_reg <= 1'b0;
				if (wd[`UOE_EV_DISABLED] && !dis_finish)
					dis_ev_reg <= 1'b0;
				if (wd[`UOE_EV_SETUP] && !setup_hit)
					setup_ev_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Handshake to the packet engine
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			epx_handshake <= `UOE_HS_NONE;
			epx_snoop <= 1'b0;
			epx_pid <= 1'b0;
		end else if (aclken) begin
			epx_snoop <= snoop_reg; // [RULE22]
			epx_pid <= pid_reg;
			if (epx_setup_token)
				epx_handshake <= `UOE_HS_ACK; // [RULE21]
			else if (!epx_out_data)
				epx_handshake <= `UOE_HS_NONE;
			else if (stall_reg && type_reg != `UOE_TYPE_ISO)
				epx_handshake <= `UOE_HS_STALL; // [RULE19]
			else if (nak_reg || !enable_reg)
				epx_handshake <= `UOE_HS_NAK; // [RULE18]
			else
				epx_handshake <= `UOE_HS_ACK;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	reg [31:0] rd_mux;
	reg rd_ok;
	always @* begin
		rd_mux = 32'h0000_0000;
		rd_ok = 1'b1;
		if (is_reg(s_axi_araddr, `UOE_OFF_EP0_TSIZE))
			rd_mux = {1'b0, setup_cnt_reg, 9'h000, pkt_cnt_reg,
				12'h000, bytes_reg};
		else if (is_reg(s_axi_araddr, `UOE_OFF_EP0_DMA))
			rd_mux = dma_reg;
		else if (is_reg(s_axi_araddr, `UOE_OFF_EPX_CTL))
			rd_mux = {enable_reg, disable_reg, 8'h00, stall_reg,
				snoop_reg, type_reg, nak_reg, pid_reg, 16'h0000};
		else if (is_reg(s_axi_araddr, `UOE_OFF_EVENTS))
			rd_mux = {28'h0000000, setup_ev_reg, 1'b0, dis_ev_reg,
				done_ev_reg};
		else if (is_reg(s_axi_araddr, `UOE_OFF_EP0_EVENTS))
			rd_mux = {25'h0000000, ep0_b2b_reg, 2'h0, ep0_setup_ev_reg,
				2'h0, ep0_done_reg};
		else
			rd_ok = 1'b0;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (aclken) begin
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? 2'h0 : 2'h3;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// file: sim/uoe_ctl_monitor.sv
// Port checker for the OUT endpoint control block
`timescale 1ns/100ps
`include "uoe_map.vh"
module uoe_ctl_monitor (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Register bus
	input wire [17:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Endpoint x
	input wire epx_setup_token,
	input wire epx_out_data,
	input wire [1:0] epx_handshake,
	input wire epx_snoop,
	input wire epx_pid
);
	wire both_tk;
	wire ctl_wr;
	reg [31:0] wd_reg;
	assign both_tk = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready;
	assign ctl_wr = both_tk && s_axi_awaddr == `UOE_OFF_EPX_CTL;
	// Copies lag the write, so the written word is kept for them
	always @(posedge aclk) begin
		if (ctl_wr)
			wd_reg <= s_axi_wdata;
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking mon_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	bvalid_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	write_answer_a: assert property (both_tk |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	write_block_a: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	setup_ack_a: assert property (
		epx_setup_token |=> epx_handshake == `UOE_HS_ACK)
		else $error("setup packet not acknowledged");
	setup_nak_a: assert property (
		epx_setup_token && !s_axi_awvalid ##1 epx_out_data && !s_axi_awvalid
		|=> epx_handshake == `UOE_HS_NAK)
		else $error("data after setup not refused");
	snoop_copy_a: assert property (
		ctl_wr |-> ##[1:3] epx_snoop == wd_reg[`UOE_CTL_SNOOP])
		else $error("snoop copy does not follow write");
	pid_load_a: assert property (
		ctl_wr && (s_axi_wdata[29] || s_axi_wdata[28])
		|-> ##[1:3] epx_pid == wd_reg[`UOE_CTL_SET_PID1])
		else $error("pid field not loaded");
endmodule
bind uoe_out_ep_ctrl uoe_ctl_monitor mon_u (.*);

// file: sim/uoe_host_model.sv
// Model of the USB packet engine facing the endpoint logic
`timescale 1ns/100ps
module uoe_host_model (
	// Clock
	input wire aclk,
	// Endpoint 0 events
	output wire ep0_setup_rx,
	output reg [63:0] ep0_setup_data,
	output wire ep0_beat,
	output wire ep0_pkt_stored,
	output reg [6:0] ep0_pkt_bytes,
	output wire ep0_usb_done,
	// Endpoint x events
	output wire epx_setup_token,
	output wire epx_out_data,
	output wire epx_disable_ack,
	output wire epx_xfer_done
);
	reg [7:0] pulse_reg = 8'h00;
	initial ep0_pkt_bytes = 7'h00;
	initial ep0_setup_data = 64'h0123456789ABCDEF;
	assign {epx_xfer_done, epx_disable_ack, epx_out_data, epx_setup_token,
		ep0_usb_done, ep0_pkt_stored, ep0_beat, ep0_setup_rx} = pulse_reg;
	// Payload flips each cycle so stale data never looks valid
	always @(posedge aclk)
		ep0_setup_data <= ~ep0_setup_data;
	task send(input integer k, input [6:0] n);
		begin
			pulse_reg <= 8'h01 << k;
			ep0_pkt_bytes <= n;
			@(posedge aclk);
		end
	endtask
	// Byte count is not held once its pulse is over
	task idle;
		begin
			pulse_reg <= 8'h00;
			ep0_pkt_bytes <= ~ep0_pkt_bytes;
		end
	endtask
endmodule

// file: sim/uoe_out_ep_ctrl_tb.sv
// Self-checking bench for the OUT endpoint control block
`timescale 1ns/100ps
`include "uoe_map.vh"
module uoe_out_ep_ctrl_tb;
	localparam [17:0] ctl_a = `UOE_OFF_EPX_CTL;
	localparam [17:0] evx_a = `UOE_OFF_EVENTS;
	localparam [17:0] ev0_a = `UOE_OFF_EP0_EVENTS;
	localparam [17:0] ts_a = `UOE_OFF_EP0_TSIZE;
	localparam [31:0] full = 32'hFFFFFFFF;
	reg aclk, aresetn, aclken, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg s_axi_arvalid, s_axi_rready;
	reg [17:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata, r, e;
	reg [63:0] sd;
	reg [3:0] s_axi_wstrb;
	reg [1:0] ep0_setup_rd_idx;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, epx_snoop, epx_pid;
	wire [1:0] s_axi_bresp, s_axi_rresp, epx_handshake;
	wire [31:0] s_axi_rdata;
	wire ep0_setup_rx, ep0_beat, ep0_pkt_stored, ep0_usb_done;
	wire epx_setup_token, epx_out_data, epx_disable_ack, epx_xfer_done;
	wire [63:0] ep0_setup_data, ep0_setup_rd_data;
	wire [6:0] ep0_pkt_bytes;
	integer fail_count, total_checks, seed, i;
	reg [65:0] rq[$];
	reg [1:0] hq[$];
	reg [63:0] tbl [0:4] = '{64'h20000000_00010000, 64'h30000000_00010000,
		64'h10000000_00000000, 64'h00100000_00100000, 64'h0};
	uoe_out_ep_ctrl dut_u (.*);
	uoe_host_model host_u (.*);
	initial begin
		aclk = 1'h0;
		forever #4 aclk = ~aclk;
	end
	// ----------------------------------------
	// Driver tasks
	// ----------------------------------------
	task chk(input string n, input [63:0] s, input [63:0] x);
		begin
			total_checks = total_checks + 1;
			if (s !== x) begin
				fail_count = fail_count + 1;
				$display("FAIL %0s expected %h seen %h", n, x, s);
			end
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", total_checks, fail_count);
			if (fail_count == 0 && total_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task lim(input reg b);
		begin
			if (b) begin
				fail_count = fail_count + 1;
				$display("FAIL wait expected answer seen timeout");
				end_sim;
			end
		end
	endtask
	task wr(input [17:0] a, input [31:0] d, input [1:0] x);
		integer k;
		reg b;
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			b = 1'h1;
			for (k = 0; k < 40 && b; k++) begin
				@(posedge aclk);
				s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
				s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
				b = !s_axi_bvalid;
				s_axi_bready <= b;
			end
			if (!b)
				chk("bresp", s_axi_bresp, x);
			lim(b);
			@(posedge aclk);
		end
	endtask
	task rd(input [17:0] a, input [31:0] m, input [31:0] x, input [1:0] p);
		integer k;
		reg b;
		begin
			rq.push_back({p, m, x});
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			b = 1'h1;
			for (k = 0; k < 40 && b; k++) begin
				@(posedge aclk);
				s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
				b = !s_axi_rvalid;
				s_axi_rready <= b;
			end
			lim(b);
			@(posedge aclk);
		end
	endtask
	task ev(input integer k, input [6:0] n);
		begin
			host_u.send(k, n);
			host_u.idle();
			@(posedge aclk);
		end
	endtask
	task ox(input [31:0] d, input [1:0] h);
		begin
			wr(ctl_a, d, 2'h0);
			hq.push_back(h);
			ev(5, 7'h00);
		end
	endtask
	// Results are matched against the oldest note when they appear
	always @(negedge aclk) begin : watch
		reg [65:0] x;
		if (s_axi_rvalid && s_axi_rready) begin
			x = rq.pop_front();
			chk("rdata", s_axi_rdata & x[63:32], x[31:0]);
			chk("rresp", s_axi_rresp, x[65:64]);
		end
		if (aresetn && epx_handshake !== `UOE_HS_NONE)
			chk("handshake", epx_handshake, hq.pop_front());
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		fail_count = 0;
		total_checks = 0;
		seed = 65;
		{aresetn, aclken, s_axi_awvalid, s_axi_wvalid} = 4'h4;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 68'h0;
		s_axi_wstrb = 4'hF;
		ep0_setup_rd_idx = 2'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rd(ts_a, full, `UOE_RST_TSIZE, 2'h0);
		rd(`UOE_OFF_EP0_DMA, full, `UOE_RST_DMA, 2'h0);
		rd(ctl_a, full, 32'h0, 2'h0);
		rd(18'h00004, full, 32'h0, 2'h3);
		wr(18'h00004, full, 2'h3);
		$display("test reset and unmapped done");
		// The pointer only moves while endpoint 0 is armed
		wr(ts_a, 32'h60080040, 2'h0);
		r = $random(seed) & 32'hFFFFFFFC;
		wr(`UOE_OFF_EP0_DMA, r, 2'h0);
		for (i = 0; i < 3; i++)
			ev(1, 7'h00);
		e = r + 3 * `UOE_BUS_BEAT;
		rd(`UOE_OFF_EP0_DMA, full, e, 2'h0);
		$display("test dma pointer done");
		ev(2, 7'h20);
		rd(ts_a, 32'h7F, 32'h20, 2'h0);
		ev(2, 7'h20);
		rd(ev0_a, 32'h1, 32'h0, 2'h0);
		ev(3, 7'h00);
		rd(ev0_a, 32'h1, 32'h1, 2'h0);
		wr(ev0_a, full, 2'h0);
		// Each SETUP disarms endpoint 0, so software rearms it in between
		for (i = 0; i < 4; i++) begin
			wr(ts_a, 32'h60000040, 2'h0);
			host_u.send(0, 7'h00);
			sd = ep0_setup_data;
			host_u.idle();
			@(posedge aclk);
		end
		rd(ev0_a, 32'h40, 32'h40, 2'h0);
		chk("setup store", ep0_setup_rd_data, sd);
		$display("test endpoint 0 transfer done");
		ox(32'h80280000, `UOE_HS_STALL);
		ox(32'h88280000, `UOE_HS_STALL);
		ox(32'h80080000, `UOE_HS_NAK);
		ox(32'h84080000, `UOE_HS_ACK);
		rd(ctl_a, full, 32'h80080000, 2'h0);
		wr(ctl_a, 32'h80200000, 2'h0);
		hq.push_back(`UOE_HS_ACK);
		hq.push_back(`UOE_HS_NAK);
		host_u.send(4, 7'h00);
		host_u.send(5, 7'h00);
		host_u.idle();
		rd(ctl_a, full, 32'h00020000, 2'h0);
		rd(evx_a, 32'h8, 32'h8, 2'h0);
		$display("test handshakes done");
		wr(evx_a, full, 2'h0);
		wr(ctl_a, 32'h84000000, 2'h0);
		ev(7, 7'h00);
		rd(evx_a, 32'h3, 32'h1, 2'h0);
		rd(ctl_a, 32'h80000000, 32'h0, 2'h0);
		wr(evx_a, full, 2'h0);
		wr(ctl_a, 32'h80000000, 2'h0);
		wr(ctl_a, 32'hC0000000, 2'h0);
		ev(6, 7'h00);
		rd(evx_a, 32'h3, 32'h2, 2'h0);
		rd(ctl_a, 32'hC0000000, 32'h0, 2'h0);
		$display("test done and disable done");
		for (i = 0; i < 6; i++) begin
			r = i < 5 ? tbl[i][63:32] : $random(seed) & 32'h00100000;
			e = i < 5 ? tbl[i][31:0] : r;
			wr(ctl_a, r, 2'h0);
			rd(ctl_a, 32'h00110000, e, 2'h0);
		end
		$display("test pid and snoop done");
		chk("queues", hq.size() + rq.size(), 0);
		end_sim;
	end
endmodule
